/* File: rtl/cst_pkg.sv */
// Shared constants, types and helper functions for the settle timer block
package cst_pkg;

  // ==========================================================
  // Sizes
  localparam int NCH = 4;
  localparam int CODE_W = 16;
  localparam int DIV_W = 10;
  localparam int CYC_W = 20;

  // ==========================================================
  // Register word indices, byte address is four times the index
  localparam logic [5:0] CH3_FREQUENCY_OFFSET_IDX = 6'h0f;
  localparam logic [5:0] CH0_SETTLE_INTERVAL_IDX = 6'h10;
  localparam logic [5:0] CH1_SETTLE_INTERVAL_IDX = 6'h11;
  localparam logic [5:0] CH2_SETTLE_INTERVAL_IDX = 6'h12;
  localparam logic [5:0] CH3_SETTLE_INTERVAL_IDX = 6'h13;
  localparam logic [5:0] CH0_REF_DIVIDER_IDX = 6'h14;
  localparam logic [5:0] EVENT_STATUS_IDX = 6'h18;
  localparam logic [5:0] EVENT_MASK_IDX = 6'h19;
  localparam logic [5:0] SETTLE_CTRL_IDX = 6'h1a;

  // ==========================================================
  // Field positions
  localparam int STAT_DONE_LSB = 0;
  localparam int STAT_AMP_LSB = 4;
  localparam int STAT_W = 8;
  localparam int CTRL_AMP_REPORT_BIT = 0;
  localparam int REF_DIV_LSB = 0;
  localparam int OFFSET_FRAC_BITS = 16;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_FREQ_OFFSET = 16'h0000;
  localparam logic [15:0] RST_STABILISE = 16'h0000;
  localparam logic [9:0] RST_REF_DIVISOR = 10'h000;
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;
  localparam logic RST_AMP_REPORT = 1'b0;

  // ==========================================================
  // Timing counts, in reference-clock cycles
  localparam logic [15:0] SHORT_CODE_MAX = 16'h0001;
  localparam logic [19:0] SHORT_SETTLE_CYC = 20'h00020;
  localparam int SETTLE_UNIT_SHIFT = 4;

  typedef enum logic {CST_IDLE, CST_SETTLE} cst_state_t;

  // Settling length in reference cycles for a programmed code
  function automatic logic [19:0] settle_cycles(input logic [15:0] code);
    if (code <= SHORT_CODE_MAX)
      return SHORT_SETTLE_CYC;
    return 20'(code) << SETTLE_UNIT_SHIFT;
  endfunction

  // Divider zero is reserved; run it as divide-by-one
  function automatic logic [9:0] div_eff(input logic [9:0] div);
    return (div == 10'h000) ? 10'h001 : div;
  endfunction

endpackage

/* File: rtl/cst_ref_div.sv */
// Reference clock divider producing one tick per reference period
`timescale 1ns/1ps
module cst_ref_div
  import cst_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic restart_i,
  input wire logic run_i,
  input wire logic [9:0] div_i,
  output logic tick_o
);

  logic [9:0] cnt_q;

  // Phase restarts with each settling phase so the interval is exact
  assign tick_o = run_i && !restart_i && (cnt_q == div_eff(div_i) - 10'h001);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      cnt_q <= 10'h000;
    else if (ce_i)
    begin
      if (restart_i || tick_o)
        cnt_q <= 10'h000;
      else if (run_i)
        cnt_q <= cnt_q + 10'h001;
    end
  end

  chk_tick_spacing: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && tick_o && div_eff(div_i) >= 10'h002) |=> !tick_o)
    else $error("reference tick repeated inside one divider period");

endmodule

/* File: rtl/cst_settle_cnt.sv */
// Per-channel settle interval counter
`timescale 1ns/1ps
module cst_settle_cnt
  import cst_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic [15:0] code_i,
  output logic busy_o,
  output logic done_o
);

  cst_state_t state_q;
  logic [19:0] remain_q;
  logic done_q;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q <= CST_IDLE;
      remain_q <= 20'h00000;
      done_q <= 1'b0;
    end
    else if (ce_i)
    begin
      done_q <= 1'b0;
      if (start_i)
      begin
        // A new start during settling restarts the interval
        remain_q <= settle_cycles(code_i);
        state_q <= CST_SETTLE;
      end
      else
      begin
        unique case (state_q)
          CST_IDLE:
          begin
          end
          CST_SETTLE:
          begin
            if (tick_i)
            begin
              remain_q <= remain_q - 20'h00001;
              if (remain_q == 20'h00001)
              begin
                state_q <= CST_IDLE;
                done_q <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  assign busy_o = (state_q == CST_SETTLE);
  assign done_o = done_q;

  chk_load_count: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && start_i) |=> (busy_o && remain_q == settle_cycles($past(code_i))))
    else $error("settle count not loaded at start of settling");

endmodule

/* File: rtl/cst_top.sv */
// Settle timer, frequency offset register and Wishbone slave, four channels
//
// Behaviour
// - Channel 3 offset value is a fraction of 2^16 of channel 3 reference.
// - Each conversion waits for its channel's programmed settle interval first.
// - Codes 0x0000 and 0x0001 give exactly 32 reference cycles of settling.
// - Codes 0x0002 to 0xFFFF settle for sixteen reference cycles per unit.
// - Unsettled amplitude at conversion start flags error when reporting enabled.
// - Reference clock is input clock over channel divider; zero is reserved.
`timescale 1ns/1ps
module cst_top
  import cst_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] settle_start_i,
  input wire logic [3:0] amp_settled_i,
  output logic [3:0] conv_start_o,
  output logic [3:0] settling_o,
  output logic [15:0] ch3_freq_shift_value_o,
  output logic irq_o
);

  // ==========================================================
  // Helpers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
      res[7:0] = dat[7:0];
    if (sel[1])
      res[15:8] = dat[15:8];
    return res;
  endfunction

  // ==========================================================
  // Register state
  logic [15:0] ch3_freq_shift_value_q;
  logic [15:0] stabilise_count_q [NCH];
  logic [9:0] reference_divisor_q [NCH];
  logic [STAT_W-1:0] status_q;
  logic [STAT_W-1:0] mask_q;
  logic amp_report_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;

  logic [5:0] idx;
  logic access;
  logic wr;

  assign idx = wb_adr_i[7:2];
  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = access && wb_we_i;

  // ==========================================================
  // Amplitude-settled pins, three stages, filtered on agreement
  logic [3:0] amp_s1_q;
  logic [3:0] amp_s2_q;
  logic [3:0] amp_s3_q;
  logic [3:0] amp_ok_q;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      amp_s1_q <= 4'h0;
      amp_s2_q <= 4'h0;
      amp_s3_q <= 4'h0;
      amp_ok_q <= 4'h0;
    end
    else if (ce_i)
    begin
      amp_s1_q <= amp_settled_i;
      amp_s2_q <= amp_s1_q;
      amp_s3_q <= amp_s2_q;
      for (int c = 0; c < NCH; c++)
        if (amp_s2_q[c] == amp_s3_q[c])
          amp_ok_q[c] <= amp_s3_q[c];
    end
  end

  // ==========================================================
  // Channel timers
  logic [3:0] tick_w;
  logic [3:0] busy_w;
  logic [3:0] done_w;

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    cst_ref_div u_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .restart_i(settle_start_i[g]),
      .run_i(busy_w[g]),
      .div_i(reference_divisor_q[g]),
      .tick_o(tick_w[g])
    );

    cst_settle_cnt u_cnt (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .start_i(settle_start_i[g]),
      .tick_i(tick_w[g]),
      .code_i(stabilise_count_q[g]),
      .busy_o(busy_w[g]),
      .done_o(done_w[g])
    );
  end

  // ==========================================================
  // Conversion start and amplitude check
  logic [3:0] amp_evt;

  // Amplitude is judged as the conversion is launched
  assign amp_evt = done_w & ~amp_ok_q & {NCH{amp_report_q}};

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      conv_start_o <= 4'h0;
      settling_o <= 4'h0;
    end
    else if (ce_i)
    begin
      conv_start_o <= done_w;
      settling_o <= busy_w;
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      ch3_freq_shift_value_q <= RST_FREQ_OFFSET;
    else if (ce_i && wr && idx == CH3_FREQUENCY_OFFSET_IDX)
      ch3_freq_shift_value_q <= merge16(ch3_freq_shift_value_q, wb_dat_i,
                                        wb_sel_i);
  end

  // Value is a fraction of 2^16 of the channel 3 reference frequency
  assign ch3_freq_shift_value_o = ch3_freq_shift_value_q;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int c = 0; c < NCH; c++)
        stabilise_count_q[c] <= RST_STABILISE;
    end
    else if (ce_i && wr)
    begin
      for (int c = 0; c < NCH; c++)
        if (idx == CH0_SETTLE_INTERVAL_IDX + 6'(c))
          stabilise_count_q[c] <= merge16(stabilise_count_q[c], wb_dat_i,
                                          wb_sel_i);
    end
  end

  logic [15:0] div_merge [NCH];

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
      div_merge[c] = merge16({6'h00, reference_divisor_q[c]}, wb_dat_i,
                             wb_sel_i);
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int c = 0; c < NCH; c++)
        reference_divisor_q[c] <= RST_REF_DIVISOR;
    end
    else if (ce_i && wr)
    begin
      for (int c = 0; c < NCH; c++)
        if (idx == CH0_REF_DIVIDER_IDX + 6'(c))
          reference_divisor_q[c] <= div_merge[c][REF_DIV_LSB +: DIV_W];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mask_q <= RST_EVENT_MASK;
      amp_report_q <= RST_AMP_REPORT;
    end
    else if (ce_i && wr && wb_sel_i[0])
    begin
      if (idx == EVENT_MASK_IDX)
        mask_q <= wb_dat_i[STAT_W-1:0];
      if (idx == SETTLE_CTRL_IDX)
        amp_report_q <= wb_dat_i[CTRL_AMP_REPORT_BIT];
    end
  end

  // ==========================================================
  // Sticky events; a new event beats a clear in the same cycle
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;

  assign stat_set = {amp_evt, done_w};
  assign stat_clr = (wr && wb_sel_i[0] && idx == EVENT_STATUS_IDX) ?
                    wb_dat_i[STAT_W-1:0] : 8'h00;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      status_q <= 8'h00;
    else if (ce_i)
      status_q <= (status_q & ~stat_clr) | stat_set;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      irq_q <= 1'b0;
    else if (ce_i)
      irq_q <= |(status_q & mask_q);
  end

  assign irq_o = irq_q;

  // ==========================================================
  // Bus read and acknowledge
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (idx == CH3_FREQUENCY_OFFSET_IDX)
      rdata_d[15:0] = ch3_freq_shift_value_q;
    if (idx == EVENT_STATUS_IDX)
      rdata_d[STAT_W-1:0] = status_q;
    if (idx == EVENT_MASK_IDX)
      rdata_d[STAT_W-1:0] = mask_q;
    if (idx == SETTLE_CTRL_IDX)
      rdata_d[CTRL_AMP_REPORT_BIT] = amp_report_q;
    for (int c = 0; c < NCH; c++)
    begin
      if (idx == CH0_SETTLE_INTERVAL_IDX + 6'(c))
        rdata_d[15:0] = stabilise_count_q[c];
      if (idx == CH0_REF_DIVIDER_IDX + 6'(c))
        rdata_d[DIV_W-1:0] = reference_divisor_q[c];
    end
  end

  // Unmapped words are acknowledged, read zero and ignore writes
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_q <= access;
      if (access && !wb_we_i)
        rdata_q <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ==========================================================
  // Checking helpers: measured and expected settle spans
  logic [31:0] meas_q [NCH];
  logic [31:0] exp_q [NCH];
  logic [15:0] code_cap_q [NCH];
  logic [9:0] div_cap_q [NCH];

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        meas_q[c] <= 32'h0000_0000;
        exp_q[c] <= 32'h0000_0000;
        code_cap_q[c] <= 16'h0000;
        div_cap_q[c] <= 10'h000;
      end
    end
    else if (ce_i)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (settle_start_i[c])
        begin
          meas_q[c] <= 32'h0000_0000;
          exp_q[c] <= 32'(settle_cycles(stabilise_count_q[c])) *
                      32'(div_eff(reference_divisor_q[c]));
          code_cap_q[c] <= stabilise_count_q[c];
          div_cap_q[c] <= div_eff(reference_divisor_q[c]);
        end
        else
          meas_q[c] <= meas_q[c] + 32'h0000_0001;
      end
    end
  end

  for (genvar g = 0; g < NCH; g++)
  begin : g_chk
    chk_settle_span: assert property (@(posedge clk_i)
      disable iff (reset_i)
      done_w[g] |-> meas_q[g] == exp_q[g])
      else $error("settle interval length wrong");

    chk_short_code: assert property (@(posedge clk_i)
      disable iff (reset_i)
      (done_w[g] && code_cap_q[g] <= SHORT_CODE_MAX) |->
        meas_q[g] == 32'(div_cap_q[g]) * 32'h0000_0020)
      else $error("short code did not settle for 32 reference cycles");

    chk_long_code: assert property (@(posedge clk_i)
      disable iff (reset_i)
      (done_w[g] && code_cap_q[g] > SHORT_CODE_MAX) |->
        meas_q[g] == 32'(div_cap_q[g]) * {12'h000, code_cap_q[g], 4'h0})
      else $error("long code not sixteen cycles per unit");

    chk_start_follow: assert property (@(posedge clk_i)
      disable iff (reset_i || !ce_i)
      done_w[g] |=> conv_start_o[g] ##1 !conv_start_o[g])
      else $error("conversion start not a single pulse after settling");

    chk_amp_error: assert property (@(posedge clk_i)
      disable iff (reset_i || !ce_i)
      (done_w[g] && !amp_ok_q[g] && amp_report_q) |=>
        status_q[STAT_AMP_LSB + g] && conv_start_o[g])
      else $error("amplitude error not flagged at conversion start");

    chk_amp_quiet: assert property (@(posedge clk_i)
      disable iff (reset_i || !ce_i)
      (!status_q[STAT_AMP_LSB + g] && !(done_w[g] && amp_report_q)) |=>
        !status_q[STAT_AMP_LSB + g])
      else $error("amplitude error set while not reportable");
  end

  chk_offset_write: assert property (@(posedge clk_i)
    disable iff (reset_i || !ce_i)
    (wr && idx == CH3_FREQUENCY_OFFSET_IDX && wb_sel_i[1:0] == 2'b11) |=>
      ch3_freq_shift_value_o == $past(wb_dat_i[15:0]))
    else $error("offset register did not take written value");

  chk_irq_level: assert property (@(posedge clk_i)
    disable iff (reset_i || !ce_i)
    ##1 irq_o == $past(|(status_q & mask_q)))
    else $error("interrupt does not follow masked status");

endmodule

/* File: tb/cst_top_tb_top.sv */
// Self-checking bench for the four-channel settle timer block
`timescale 1ns/1ps
module cst_top_tb_top
  import cst_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] settle_start_i = 4'h0;
  logic [3:0] amp_settled_i = 4'hf;
  logic [3:0] conv_start_o;
  logic [3:0] settling_o;
  logic [15:0] ch3_freq_shift_value_o;
  logic irq_o;
  int fail_count = 0;
  int cmp_count = 0;
  int cycle_cnt = 0;
  logic [31:0] rd;

  cst_top dut_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .settle_start_i(settle_start_i),
    .amp_settled_i(amp_settled_i),
    .conv_start_o(conv_start_o),
    .settling_o(settling_o),
    .ch3_freq_shift_value_o(ch3_freq_shift_value_o),
    .irq_o(irq_o)
  );

  // ==========================================================
  // Clock, timeout and shared tasks
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  // Longest test runs well under a thousand cycles; generous ceiling
  always @(posedge clk_i)
  begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 5000)
    begin
      $display("Error at %0t: timeout cycles %h", $time, cycle_cnt);
      fail_count = fail_count + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count = fail_count + 1;
    end
  endtask

  // One classic cycle; ack and read data are taken at the same rising edge
  task automatic wb_xfer(input logic we, input logic [5:0] idx,
                         input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    do
    begin
      @(posedge clk_i);
      n = n + 1;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
      chk(32'h0, 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] q;
    wb_xfer(1'b1, idx, wd, q);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, idx, 32'h0, q);
    chk(q, exp);
  endtask

  // Pulse a start and count edges from the taking edge to conv_start_o
  task automatic run_settle(input int c, input int exp_edges);
    int n;
    @(posedge clk_i);
    settle_start_i <= 4'h1 << c;
    @(posedge clk_i);
    settle_start_i <= 4'h0;
    n = 0;
    #1;
    while (conv_start_o[c] !== 1'b1 && n < 3000)
    begin
      @(posedge clk_i);
      #1;
      n = n + 1;
      if (n == 1)
        chk(settling_o[c], 1'b1);
    end
    chk(n, exp_edges);
    chk(conv_start_o, 4'h1 << c);
    @(posedge clk_i);
    #1;
    chk(conv_start_o, 4'h0);
    chk(settling_o[c], 1'b0);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd_chk(CH3_FREQUENCY_OFFSET_IDX, 32'h0000_0000);
    rd_chk(CH0_SETTLE_INTERVAL_IDX, 32'h0000_0000);
    rd_chk(CH1_SETTLE_INTERVAL_IDX, 32'h0000_0000);
    rd_chk(CH2_SETTLE_INTERVAL_IDX, 32'h0000_0000);
    rd_chk(CH3_SETTLE_INTERVAL_IDX, 32'h0000_0000);
    chk(ch3_freq_shift_value_o, 16'h0000);
    wr(CH3_FREQUENCY_OFFSET_IDX, 32'hffff_a5c3);
    rd_chk(CH3_FREQUENCY_OFFSET_IDX, 32'h0000_a5c3);
    chk(ch3_freq_shift_value_o, 16'ha5c3);
    wr(CH2_SETTLE_INTERVAL_IDX, 32'h0000_ffff);
    rd_chk(CH2_SETTLE_INTERVAL_IDX, 32'h0000_ffff);
    // Unmapped word: write must not land anywhere
    wr(6'h3f, 32'h1234_5678);
    rd_chk(6'h3f, 32'h0000_0000);
    rd_chk(CH3_FREQUENCY_OFFSET_IDX, 32'h0000_a5c3);
    $display("test regs done");
  endtask

  task automatic t_timing(input int c, input logic [15:0] code,
                          input logic [9:0] div);
    int n_ref;
    int n_div;
    n_ref = (code <= 16'h0001) ? 32 : 16 * int'(code);
    // Reserved divider zero runs as divide-by-one
    n_div = (div == 10'h000) ? 1 : int'(div);
    wr(CH0_SETTLE_INTERVAL_IDX + 6'(c), {16'h0, code});
    wr(CH0_REF_DIVIDER_IDX + 6'(c), {22'h0, div});
    rd_chk(CH0_REF_DIVIDER_IDX + 6'(c), {22'h0, div});
    run_settle(c, n_ref * n_div + 1);
    rd_chk(EVENT_STATUS_IDX, 32'h1 << c);
    wr(EVENT_STATUS_IDX, 32'h1 << c);
    rd_chk(EVENT_STATUS_IDX, 32'h0);
    $display("test timing ch%0d code %h div %h done", c, code, div);
  endtask

  task automatic t_amp();
    wr(CH0_SETTLE_INTERVAL_IDX, 32'h0);
    wr(CH0_REF_DIVIDER_IDX, 32'h1);
    wr(SETTLE_CTRL_IDX, 32'h1);
    wr(EVENT_MASK_IDX, 32'h10);
    amp_settled_i <= 4'he;
    run_settle(0, 33);
    rd_chk(EVENT_STATUS_IDX, 32'h11);
    #1;
    chk(irq_o, 1'b1);
    wr(EVENT_MASK_IDX, 32'h0);
    #1;
    chk(irq_o, 1'b0);
    wr(EVENT_STATUS_IDX, 32'h11);
    rd_chk(EVENT_STATUS_IDX, 32'h0);
    // Reporting off: the unsettled pin must stay silent
    wr(SETTLE_CTRL_IDX, 32'h0);
    run_settle(0, 33);
    rd_chk(EVENT_STATUS_IDX, 32'h01);
    wr(EVENT_STATUS_IDX, 32'h01);
    // Reporting on, amplitude settled: no error either
    wr(SETTLE_CTRL_IDX, 32'h1);
    amp_settled_i <= 4'hf;
    run_settle(0, 33);
    rd_chk(EVENT_STATUS_IDX, 32'h01);
    wr(EVENT_STATUS_IDX, 32'h01);
    $display("test amplitude done");
  endtask

  // Ten frozen cycles mid-settle must stretch the interval by ten
  task automatic t_freeze();
    int n;
    wr(CH0_SETTLE_INTERVAL_IDX, 32'h0);
    wr(CH0_REF_DIVIDER_IDX, 32'h1);
    @(posedge clk_i);
    settle_start_i <= 4'h1;
    @(posedge clk_i);
    settle_start_i <= 4'h0;
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    ce_i <= 1'b1;
    n = 14;
    #1;
    chk(settling_o[0], 1'b1);
    while (conv_start_o[0] !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      #1;
      n = n + 1;
    end
    chk(n, 43);
    rd_chk(EVENT_STATUS_IDX, 32'h01);
    wr(EVENT_STATUS_IDX, 32'h01);
    $display("test clock enable freeze done");
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_timing(0, 16'h0000, 10'h001);
    t_timing(1, 16'h0001, 10'h001);
    t_timing(2, 16'h0002, 10'h003);
    t_timing(3, 16'h0005, 10'h002);
    t_timing(1, 16'h0001, 10'h000);
    t_amp();
    t_freeze();
    finish_test();
  end
endmodule
